// ==== rtl/adcsr_top.sv ====
// two-wire readout, offset calibration and standby control
//
// Summary of operation
// - next result bit on each clock rise
// - result is 24 bits, MSB first
// - unread result overwritten by next one
// - continuous conversion, 12.5 or 100 ms
// - output holds last bit until update
// - 25th pulse forces output high
// - falling edge of 26th pulse starts calibration
// - calibration disconnects analog inputs
// - calibration end drives output low
// - first post-calibration result after 101.28/801.02 ms
// - standby after 12.44 or 99.94 ms high
// - standby allowed anywhere during readback
// - standby powers analog circuitry down
// - output high during standby, clock held
// - clock low wakes, next result valid
// - timing scales with master clock period
// - result in two's complement form
`timescale 1ns/1ps
module adcsr_top #(
  parameter int CONV_FAST_CYC = adcsr_pkg::CONV_FAST_CYC,
  parameter int CONV_SLOW_CYC = adcsr_pkg::CONV_SLOW_CYC,
  parameter int CAL_FAST_CYC = adcsr_pkg::CAL_FAST_CYC,
  parameter int CAL_SLOW_CYC = adcsr_pkg::CAL_SLOW_CYC,
  parameter int STBY_FAST_CYC = adcsr_pkg::STBY_FAST_CYC,
  parameter int STBY_SLOW_CYC = adcsr_pkg::STBY_SLOW_CYC,
  parameter int UPD_CYC = adcsr_pkg::UPD_CYC
) (
  // master clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // serial clock from host
  input wire logic SCLK_LINK,
  // rate select pin
  input wire logic SPEED,
  // filter result, same clock
  input wire logic [adcsr_pkg::DATA_W-1:0] SAMPLE,
  // ready/data pin
  output logic READY_DATA_OUT,
  // analog front end control
  output adcsr_pkg::adcsr_analog_t ANALOG
);
  localparam int DW = adcsr_pkg::DATA_W;
  localparam int CW = adcsr_pkg::CNT_W;
  localparam int TW = adcsr_pkg::TMR_W;
  localparam int BW = adcsr_pkg::BIT_W;

  // every timed count is a cycle count of the master clock
  localparam logic [TW-1:0] CONV_F = TW'(CONV_FAST_CYC);
  localparam logic [TW-1:0] CONV_S = TW'(CONV_SLOW_CYC);
  localparam logic [TW-1:0] CAL_F = TW'(CAL_FAST_CYC);
  localparam logic [TW-1:0] CAL_S = TW'(CAL_SLOW_CYC);
  localparam logic [TW-1:0] STBY_F = TW'(STBY_FAST_CYC);
  localparam logic [TW-1:0] STBY_S = TW'(STBY_SLOW_CYC);
  localparam logic [TW-1:0] UPD = TW'(UPD_CYC);

  if (CONV_SLOW_CYC >= (1 << TW) || CAL_SLOW_CYC >= (1 << TW) ||
      STBY_SLOW_CYC >= (1 << TW))
  begin : g_chk_w
    $error("adcsr_top cycle count exceeds timer width");
  end
  if (UPD_CYC < 1 || UPD_CYC + 2 >= CONV_FAST_CYC ||
      UPD_CYC + 2 >= CONV_SLOW_CYC || STBY_FAST_CYC < 1 ||
      STBY_SLOW_CYC < 1 || CAL_FAST_CYC < 1 || CAL_SLOW_CYC < 1)
  begin : g_chk_v
    $error("adcsr_top cycle counts out of range");
  end

  typedef struct packed {
    adcsr_pkg::adcsr_state_t state;
    logic [TW-1:0] tmr;
    logic [TW-1:0] stby;
    logic [DW-1:0] word;
    logic [BW-1:0] nrise;
    logic [BW-1:0] nfall;
    logic [CW-1:0] rise_seen;
    logic [CW-1:0] fall_seen;
    logic sclk;
    logic speed;
    logic dout;
    adcsr_pkg::adcsr_analog_t analog;
  } adcsr_core_t;

  localparam adcsr_core_t CORE_RST = '{
    state: adcsr_pkg::ST_CONV,
    dout: adcsr_pkg::DOUT_RST,
    analog: adcsr_pkg::ANALOG_RST,
    default: '0
  };

  adcsr_core_t st;
  adcsr_core_t next_st;

  logic [CW-1:0] rise_gray;
  logic [CW-1:0] fall_gray;
  logic [CW-1:0] rise_sync;
  logic [CW-1:0] fall_sync;
  adcsr_pkg::adcsr_pins_t pin_q;
  adcsr_pkg::adcsr_pins_t pin_p;

  // edge counters on the host clock, both edges
  adcsr_edge_cnt #(.W(CW)) u_rise (
    .clk(SCLK_LINK),
    .rst_n(RSTN),
    .gray(rise_gray)
  );

  adcsr_edge_cnt #(.W(CW)) u_fall (
    .clk(~SCLK_LINK),
    .rst_n(RSTN),
    .gray(fall_gray)
  );

  // gray counts into the master clock domain
  adcsr_sync #(.W(CW), .STAGES(adcsr_pkg::GRAY_STAGES)) u_rise_s (
    .clk(CLK),
    .rst_n(RSTN),
    .d(rise_gray),
    .q(rise_sync),
    .q_prev()
  );

  adcsr_sync #(.W(CW), .STAGES(adcsr_pkg::GRAY_STAGES)) u_fall_s (
    .clk(CLK),
    .rst_n(RSTN),
    .d(fall_gray),
    .q(fall_sync),
    .q_prev()
  );

  // pin levels: accepted when the last two stages agree
  adcsr_sync #(.W(2), .STAGES(adcsr_pkg::SYNC_STAGES)) u_pins (
    .clk(CLK),
    .rst_n(RSTN),
    .d({SPEED, SCLK_LINK}),
    .q(pin_q),
    .q_prev(pin_p)
  );

  logic rise;
  logic fall;
  logic do_load;
  logic conv_done;
  logic upd_start;
  logic cal_done;
  logic stby_done;
  logic [CW-1:0] rise_bin;
  logic [CW-1:0] fall_bin;
  logic [TW-1:0] period;
  logic [TW-1:0] cal_len;
  logic [TW-1:0] stby_len;

  always_comb
  begin
    next_st = st;
    rise_bin = adcsr_pkg::adcsr_gray2bin(rise_sync);
    fall_bin = adcsr_pkg::adcsr_gray2bin(fall_sync);
    rise = rise_bin != st.rise_seen;
    fall = fall_bin != st.fall_seen;
    next_st.rise_seen = rise_bin;
    next_st.fall_seen = fall_bin;
    if (pin_q.sclk == pin_p.sclk)
      next_st.sclk = pin_q.sclk;
    if (pin_q.speed == pin_p.speed)
      next_st.speed = pin_q.speed;
    period = st.speed ? CONV_F : CONV_S;
    cal_len = st.speed ? CAL_F : CAL_S;
    stby_len = st.speed ? STBY_F : STBY_S;
    // at-or-past compares: a rate change mid-period cannot skip an end
    conv_done = st.tmr >= period - 1'b1;
    upd_start = st.tmr >= period - UPD - 1'b1;
    cal_done = st.tmr >= cal_len - 1'b1;
    stby_done = st.stby >= stby_len - 1'b1;
    do_load = 1'b0;
    case (st.state)
      adcsr_pkg::ST_CONV:
      begin
        next_st.tmr = st.tmr + 1'b1;
        if (conv_done)
          do_load = 1'b1;
      end
      adcsr_pkg::ST_RDY:
      begin
        next_st.tmr = st.tmr + 1'b1;
        if (upd_start)
        begin
          // unread data is dropped here and replaced
          next_st.state = adcsr_pkg::ST_CONV;
          next_st.dout = 1'b1;
        end
        else if (st.sclk && stby_done)
        begin
          next_st.state = adcsr_pkg::ST_STBY;
          next_st.dout = 1'b1;
          next_st.analog.power_on = 1'b0;
        end
        else
        begin
          if (st.sclk)
            next_st.stby = st.stby + 1'b1;
          else
            next_st.stby = '0;
          if (rise)
          begin
            if (st.nrise < adcsr_pkg::LAST_DATA_PULSE)
            begin
              next_st.dout = st.word[DW-1];
              next_st.word = {st.word[DW-2:0], 1'b0};
            end
            else
              next_st.dout = 1'b1;
            if (st.nrise != adcsr_pkg::PULSE_SAT)
              next_st.nrise = st.nrise + 1'b1;
          end
          if (fall)
          begin
            if (st.nfall != adcsr_pkg::PULSE_SAT)
              next_st.nfall = st.nfall + 1'b1;
            if (st.nfall == adcsr_pkg::CAL_FALL_PREV)
            begin
              next_st.state = adcsr_pkg::ST_CAL;
              next_st.tmr = '0;
              next_st.dout = 1'b1;
              next_st.analog.inputs_connected = 1'b0;
            end
          end
        end
      end
      adcsr_pkg::ST_CAL:
      begin
        // extra host pulses are ignored here
        next_st.tmr = st.tmr + 1'b1;
        if (cal_done)
          do_load = 1'b1;
      end
      adcsr_pkg::ST_STBY:
      begin
        if (!st.sclk)
        begin
          next_st.state = adcsr_pkg::ST_CONV;
          next_st.tmr = '0;
          next_st.analog.power_on = 1'b1;
        end
      end
      default:
      begin
        next_st = CORE_RST;
      end
    endcase
    if (do_load)
    begin
      next_st.state = adcsr_pkg::ST_RDY;
      next_st.word = SAMPLE;
      next_st.dout = 1'b0;
      next_st.tmr = '0;
      next_st.stby = '0;
      next_st.nrise = '0;
      next_st.nfall = '0;
      next_st.analog.inputs_connected = 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      st <= CORE_RST;
    else
      st <= next_st;
  end

  assign READY_DATA_OUT = st.dout;
  assign ANALOG = st.analog;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  ready_low_a: assert property (
    st.state == adcsr_pkg::ST_CONV && conv_done |=>
      !READY_DATA_OUT && st.state == adcsr_pkg::ST_RDY)
    else $error("ready not signalled at conversion end");
  shift_bit_a: assert property (
    st.state == adcsr_pkg::ST_RDY && !upd_start && !stby_done && rise &&
    st.nrise < adcsr_pkg::LAST_DATA_PULSE |=>
      READY_DATA_OUT == $past(st.word[DW-1]))
    else $error("data bit not presented on rise");
  msb_load_a: assert property (
    do_load |=> st.word == $past(SAMPLE) && st.nrise == '0)
    else $error("result not loaded msb first");
  force_high_a: assert property (
    st.state == adcsr_pkg::ST_RDY && !upd_start && rise &&
    st.nrise >= adcsr_pkg::LAST_DATA_PULSE |=> READY_DATA_OUT)
    else $error("extra pulse did not force output high");
  hold_bit_a: assert property (
    st.state == adcsr_pkg::ST_RDY && !rise && !upd_start && !fall &&
    !(st.sclk && stby_done) |=> $stable(READY_DATA_OUT))
    else $error("output changed without a clock edge");
  update_high_a: assert property (
    st.state == adcsr_pkg::ST_RDY && upd_start |=>
      READY_DATA_OUT [*2])
    else $error("output not high at update start");
  cal_start_a: assert property (
    st.state == adcsr_pkg::ST_RDY && !upd_start && !stby_done && fall &&
    st.nfall == adcsr_pkg::CAL_FALL_PREV |=>
      st.state == adcsr_pkg::ST_CAL && st.tmr == '0)
    else $error("calibration not started on 26th fall");
  cal_inputs_a: assert property (
    st.state == adcsr_pkg::ST_CAL |-> !ANALOG.inputs_connected &&
      READY_DATA_OUT)
    else $error("inputs connected during calibration");
  cal_end_a: assert property (
    st.state == adcsr_pkg::ST_CAL && cal_done |=>
      !READY_DATA_OUT && ANALOG.inputs_connected)
    else $error("calibration end not signalled");
  stby_enter_a: assert property (
    st.state == adcsr_pkg::ST_RDY && !upd_start && st.sclk && stby_done
      |=> st.state == adcsr_pkg::ST_STBY && !ANALOG.power_on)
    else $error("standby not entered after hold time");
  stby_high_a: assert property (
    st.state == adcsr_pkg::ST_STBY |-> READY_DATA_OUT &&
      !ANALOG.power_on)
    else $error("standby output or power wrong");
  wake_up_a: assert property (
    st.state == adcsr_pkg::ST_STBY && !st.sclk |=>
      st.state == adcsr_pkg::ST_CONV && ANALOG.power_on)
    else $error("no wake-up on clock low");
  ready_c: cover property (st.state == adcsr_pkg::ST_RDY && rise);
  force_c: cover property (rise && st.nrise == adcsr_pkg::LAST_DATA_PULSE);
  cal_c: cover property (st.state == adcsr_pkg::ST_CAL && cal_done);
  stby_c: cover property (st.state == adcsr_pkg::ST_STBY && !st.sclk);
endmodule

// ==== rtl/adcsr_pkg.sv ====
// shared constants and types of the serial readout block
package adcsr_pkg;

  localparam int DATA_W = 24;
  localparam int CNT_W = 4;
  localparam int TMR_W = 26;
  localparam int BIT_W = 5;

  // system clock period, ns
  localparam int CLK_PERIOD_NS = 25;

  // timing at nominal master clock, ns
  localparam int CONV_FAST_NS = 12_500_000;
  localparam int CONV_SLOW_NS = 100_000_000;
  localparam int UPD_NS = 39_000;
  localparam int CAL_FAST_NS = 101_280_000;
  localparam int CAL_SLOW_NS = 801_020_000;
  localparam int STBY_FAST_NS = 12_440_000;
  localparam int STBY_SLOW_NS = 99_940_000;

  // cycle counts: least times round up, longest times round down
  localparam int CONV_FAST_CYC = CONV_FAST_NS / CLK_PERIOD_NS;
  localparam int CONV_SLOW_CYC = CONV_SLOW_NS / CLK_PERIOD_NS;
  localparam int UPD_CYC = (UPD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_FAST_CYC =
    (CAL_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_SLOW_CYC =
    (CAL_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STBY_FAST_CYC = STBY_FAST_NS / CLK_PERIOD_NS;
  localparam int STBY_SLOW_CYC = STBY_SLOW_NS / CLK_PERIOD_NS;

  // pulse numbers within one readout frame
  localparam logic [BIT_W-1:0] LAST_DATA_PULSE = 5'h18;
  localparam logic [BIT_W-1:0] CAL_FALL_PREV = 5'h19;
  localparam logic [BIT_W-1:0] PULSE_SAT = 5'h1f;

  // reset value and synchroniser depths
  localparam logic DOUT_RST = 1'b1;
  localparam int SYNC_STAGES = 3;
  localparam int GRAY_STAGES = 2;

  typedef enum logic [1:0] {
    ST_CONV = 2'b00,
    ST_RDY = 2'b01,
    ST_CAL = 2'b11,
    ST_STBY = 2'b10
  } adcsr_state_t;

  typedef struct packed {
    logic power_on;
    logic inputs_connected;
  } adcsr_analog_t;

  localparam adcsr_analog_t ANALOG_RST = 2'h3;

  typedef struct packed {
    logic speed;
    logic sclk;
  } adcsr_pins_t;

  function automatic logic [CNT_W-1:0] adcsr_gray2bin(
    input logic [CNT_W-1:0] g
  );
    logic [CNT_W-1:0] b;
    b = '0;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ==== rtl/adcsr_sync.sv ====
// multi-stage synchroniser for levels and gray words
`timescale 1ns/1ps
module adcsr_sync #(
  parameter int W = 1,
  parameter int STAGES = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous input
  input wire logic [W-1:0] d,
  // last and second-to-last stage
  output logic [W-1:0] q,
  output logic [W-1:0] q_prev
);
  typedef struct packed {
    logic [STAGES-1:0][W-1:0] stg;
  } adcsr_sync_t;

  adcsr_sync_t st;
  adcsr_sync_t next_st;

  if (STAGES < 2)
  begin : g_chk
    $error("adcsr_sync needs at least two stages");
  end

  always_comb
  begin
    next_st = st;
    next_st.stg = {st.stg[STAGES-2:0], d};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.stg[STAGES-1];
  assign q_prev = st.stg[STAGES-2];
endmodule

// ==== rtl/adcsr_edge_cnt.sv ====
// gray-coded edge counter in the link clock domain
`timescale 1ns/1ps
module adcsr_edge_cnt #(
  parameter int W = 4
) (
  // link clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // edge count, gray code
  output logic [W-1:0] gray
);
  typedef struct packed {
    logic [W-1:0] bin;
    logic [W-1:0] gray;
  } adcsr_cnt_t;

  adcsr_cnt_t st;
  adcsr_cnt_t next_st;

  if (W < 2)
  begin : g_chk
    $error("adcsr_edge_cnt needs at least two bits");
  end

  always_comb
  begin
    next_st = st;
    next_st.bin = st.bin + 1'b1;
    next_st.gray = next_st.bin ^ (next_st.bin >> 1);
  end

  // link clock may be idle during reset, so the clear is asynchronous
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign gray = st.gray;
endmodule

// ==== test/adcsr_host.sv ====
// host model: drives the serial clock, captures ready/data bits
`timescale 1ns/1ps
module adcsr_host (
  // serial clock to device
  output logic sclk,
  // ready/data pin from device
  input wire logic rdo
);
  // clock stands low outside frames unless hold_high raises it
  initial sclk = 1'b0;

  // n pulses of 125 ns, each bit taken just before the next rise
  task automatic frame(input int n, output logic [31:0] bits);
    bits = '0;
    #7;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
      #61.5;
      bits = {bits[30:0], rdo};
      #1;
    end
  endtask

  task automatic hold_high();
    #7;
    sclk = 1'b1;
  endtask

  task automatic release_clk();
    #7;
    sclk = 1'b0;
  endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench of the serial readout block
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t: got %h exp %h", $time, g, e); \
    end \
  end
module tb_top;
  localparam int CONV_F = 300;
  localparam int CONV_S = 500;
  localparam int CAL_F = 400;
  localparam int STBY_F = 150;
  localparam int UPD = 20;
  logic clk;
  logic rstn;
  logic speed;
  logic [adcsr_pkg::DATA_W-1:0] sample;
  logic sclk;
  logic rdo;
  adcsr_pkg::adcsr_analog_t analog;
  logic [31:0] bits;
  int n;
  int n1;
  int n_fail = 0;
  int checks_done = 0;

  adcsr_top #(
    .CONV_FAST_CYC(CONV_F),
    .CONV_SLOW_CYC(CONV_S),
    .CAL_FAST_CYC(CAL_F),
    .CAL_SLOW_CYC(700),
    .STBY_FAST_CYC(STBY_F),
    .STBY_SLOW_CYC(350),
    .UPD_CYC(UPD)
  ) adcsr_top_i (
    .CLK(clk),
    .RSTN(rstn),
    .SCLK_LINK(sclk),
    .SPEED(speed),
    .SAMPLE(sample),
    .READY_DATA_OUT(rdo),
    .ANALOG(analog)
  );

  adcsr_host adcsr_host_i (
    .sclk(sclk),
    .rdo(rdo)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // wait for the ready pin (or power flag) to reach v, count cycles
  task automatic wait_on(input bit pwr, input logic v, output int c);
    c = 0;
    while ((pwr ? analog.power_on : rdo) !== v && c < 2000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    if (c >= 2000)
    begin
      n_fail++;
      $display("wrong value at %0t: wait ran out", $time);
    end
  endtask

  task automatic load(input logic [23:0] w);
    @(posedge clk);
    sample <= w;
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, n);
  endtask

  task automatic t_read(input logic [23:0] w);
    load(w);
    adcsr_host_i.frame(25, bits);
    `CHK(bits[24:1], w)
    `CHK(bits[0], 1'b1)
  endtask

  task automatic t_partial();
    load(24'h5a3c96);
    adcsr_host_i.frame(8, bits);
    `CHK(bits[7:0], 8'h5a)
    repeat (30) @(posedge clk);
    #1;
    `CHK(rdo, 1'b0)
    @(posedge clk);
    sample <= 24'h123456;
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, n);
    `CHK(n >= UPD - 1 && n <= UPD + 1, 1'b1)
    adcsr_host_i.frame(25, bits);
    `CHK(bits[24:1], 24'h123456)
  endtask

  task automatic t_period(input logic s);
    int p;
    p = s ? CONV_F : CONV_S;
    @(posedge clk);
    speed <= s;
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, n);
    wait_on(0, 1'b1, n1);
    wait_on(0, 1'b0, n);
    `CHK(n + n1 >= p - 2 && n + n1 <= p + 2, 1'b1)
  endtask

  task automatic t_cal();
    load(24'h00ff00);
    adcsr_host_i.frame(26, bits);
    `CHK(bits[1:0], 2'b11)
    // host keeps the serial clock quiet while calibration runs
    repeat (4) @(posedge clk);
    #1;
    `CHK(analog.inputs_connected, 1'b0)
    `CHK(rdo, 1'b1)
    @(posedge clk);
    sample <= 24'hfedcba;
    wait_on(0, 1'b0, n);
    `CHK(n >= CAL_F - 7 && n <= CAL_F + 2, 1'b1)
    `CHK(analog.inputs_connected, 1'b1)
    adcsr_host_i.frame(25, bits);
    `CHK(bits[24:1], 24'hfedcba)
  endtask

  task automatic t_stby();
    load(24'hc0ffee);
    adcsr_host_i.frame(4, bits);
    `CHK(bits[3:0], 4'hc)
    adcsr_host_i.hold_high();
    wait_on(1, 1'b0, n);
    `CHK(n >= STBY_F && n <= STBY_F + 8, 1'b1)
    `CHK(rdo, 1'b1)
    repeat (400) @(posedge clk);
    #1;
    `CHK(rdo, 1'b1)
    `CHK(analog.power_on, 1'b0)
    @(posedge clk);
    sample <= 24'h0badc0;
    adcsr_host_i.release_clk();
    wait_on(1, 1'b1, n);
    `CHK(n <= 8, 1'b1)
    wait_on(0, 1'b0, n);
    `CHK(n >= CONV_F - 2 && n <= CONV_F + 2, 1'b1)
    adcsr_host_i.frame(25, bits);
    `CHK(bits[24:1], 24'h0badc0)
  endtask

  // watchdog: whole run needs well under 20000 cycles
  initial
  begin
    #500_000;
    n_fail++;
    close_out();
  end

  initial
  begin
    rstn = 1'b0;
    speed = 1'b1;
    sample = '0;
    // reset held for two clock edges; each edge clears every sync stage
    @(posedge clk);
    #1;
    `CHK(rdo, 1'b1)
    `CHK(analog, 2'h3)
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(rdo, 1'b1)
    t_read(24'h9c3a51);
    t_read(24'h7fffff);
    t_partial();
    t_period(1'b0);
    t_period(1'b1);
    t_cal();
    t_stby();
    close_out();
  end
endmodule
